/* logic/timer16_pkg.sv */
// package: register offsets, control bit positions, reset values, modes
package timer16_pkg;
  // byte offsets inside the timer's slice of the core memory map
  localparam logic [7:0] RELOAD_LOW_BYTE_ADDR = 8'haa;
  localparam logic [7:0] RELOAD_HIGH_BYTE_ADDR = 8'hab;
  localparam logic [7:0] COUNTER_LOW_BYTE_ADDR = 8'hac;
  localparam logic [7:0] COUNTER_HIGH_BYTE_ADDR = 8'had;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'hae;
  // control bit positions
  localparam int CTL_CAPTURE_TYPE = 1;
  localparam int CTL_IRQ_ENABLE = 2;
  localparam int CTL_PENDING = 3;
  localparam int CTL_RUN_UFL = 4;
  localparam int CTL_MODE_LOW = 5;
  localparam int CTL_MODE_MID = 6;
  localparam int CTL_MODE_HIGH = 7;
  // reset values
  localparam logic [15:0] COUNTER_RESET = 16'hffff;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESERVED_MASK = 8'hfe;
  // operating modes decoded from control bits 7:6
  typedef enum logic [1:0] {
    MODE_EVENT = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_DIFF = 2'b11
  } timer_mode_t;
  // core bus access as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } core_access_t;
endpackage

/* logic/edge_sync.sv */
// two-stage synchroniser and edge detector for the timer pin input
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  // first stage only feeds the second stage; reset to the pulled-up
  // idle level so that no false rising edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule

/* logic/multimode_timer16.sv */
// multimode 16-bit timer: pwm, event count, capture, difference capture
// Functional notes
// RULE1: 16-bit counter and reload, byte accessible
// RULE2: reset: counter ffff, reload 0, control 0
// RULE3: bit 4 runs counter; decrement per tick
// RULE4: underflow from zero loads reload or ffff
// RULE5: irq needs pending, enable and global enable
// RULE6: bit1 capture type, bit0 reserved, 7:5 mode
// RULE7: mode 10x pwm on clock, bit5 toggles
// RULE8: pwm underflow reloads and sets pending
// RULE9: pwm toggle inverts pin at each underflow
// RULE10: software clears pending, rewrites reload value
// RULE11: interrupt only on pending flag rising; the code holds a level request while a flag and both enables are set
// RULE12: mode 00x counts pin edges, bit5 polarity
// RULE13: event mode underflow reloads, sets pending
// RULE14: zero on nth event, underflow on next
// RULE15: source holds pulses one clock minimum
// RULE16: edges detected up to half clock rate
// RULE17: modes 010/011 capture rising/falling edge
// RULE18: mode 11x difference capture edge pairs
// RULE19: pin shared with port, direction register
// RULE20: capture mode free-runs, copies on edge
// RULE21: capture modes: bit4 is underflow pending
// RULE22: difference: wait edge, count up, store
// RULE23: pin input synchronised by two flops
// RULE24: hardware set beats software clear
module multimode_timer16
  import timer16_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic PIN_DIR_OUT,
  input wire logic PIN_PORT_DATA,
  input wire logic TIMER_PIN_IN,
  output logic TIMER_PIN_OUT,
  output logic TIMER_PIN_OE_N,
  output logic TIMER_IRQ
);
  core_access_t acc;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] reload_ff;
  logic [15:0] nxt_reload;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic pin_level_ff;
  logic diff_armed_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic pin_out_ff;
  logic oe_n_ff;
  logic pin_rise;
  logic pin_fall;
  timer_mode_t mode;
  logic edge_sel;
  logic tick;
  logic underflow;
  logic capture;
  logic diff_start;
  logic diff_stop;
  logic counting;

  assign acc = '{wr: BUS_WR, rd: BUS_RD, addr: BUS_ADDR, wdata: BUS_WDATA};

  // pin edges are only trusted after two sync stages [RULE23] [RULE16]
  edge_sync u_sync (
    .clk(CLOCK),
    .rst(RST),
    .din(TIMER_PIN_IN),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // true when a write hits the given byte address
  function automatic logic hit(input core_access_t a, input logic [7:0] ad);
    hit = a.wr && (a.addr == ad);
  endfunction

  // pick the polarity-selected edge: sel 0 rising, 1 falling
  function automatic logic pick_edge(input logic sel, input logic r,
                                     input logic f);
    pick_edge = sel ? f : r;
  endfunction

  // mode decode from bits 7:6, edge/toggle from bit 5 [RULE6]
  assign mode = timer_mode_t'(ctl_ff[CTL_MODE_HIGH:CTL_MODE_MID]);
  assign edge_sel = ctl_ff[CTL_MODE_LOW];

  // tick source: pin edges in event mode, clock otherwise [RULE7] [RULE12]
  always_comb begin
    tick = 1'b0;
    counting = 1'b0;
    case (mode)
      MODE_EVENT: begin
        counting = ctl_ff[CTL_RUN_UFL]; // [RULE3]
        tick = counting && pick_edge(edge_sel, pin_rise, pin_fall);
      end
      MODE_PWM: begin
        counting = ctl_ff[CTL_RUN_UFL]; // [RULE3]
        tick = counting;
      end
      MODE_CAPTURE: begin
        counting = 1'b1; // free-runs once selected [RULE20]
        tick = 1'b1;
      end
      MODE_DIFF: begin
        counting = diff_armed_ff;
        tick = diff_armed_ff;
      end
      default: begin
        counting = 1'b0;
        tick = 1'b0;
      end
    endcase
  end

  // underflow: a down step taken while at zero [RULE4] [RULE14]
  assign underflow = tick && (mode != MODE_DIFF) && (count_ff == 16'h0000);

  // capture edges; difference pairs: bit5 first edge, bit1 second [RULE18]
  always_comb begin
    capture = 1'b0;
    diff_start = 1'b0;
    diff_stop = 1'b0;
    case (mode)
      MODE_CAPTURE: begin
        capture = pick_edge(edge_sel, pin_rise, pin_fall); // [RULE17]
      end
      MODE_DIFF: begin
        diff_start = !diff_armed_ff &&
                     pick_edge(edge_sel, pin_rise, pin_fall);
        // cycle capture repeats the first edge, pulse uses the opposite
        diff_stop = diff_armed_ff &&
                    pick_edge(edge_sel ^ ~ctl_ff[CTL_CAPTURE_TYPE],
                              pin_rise, pin_fall);
        capture = diff_stop;
      end
      default: begin
        capture = 1'b0;
      end
    endcase
  end

  // difference capture arm state: waiting or counting [RULE22]
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      diff_armed_ff <= 1'b0;
    end else if (mode != MODE_DIFF) begin
      diff_armed_ff <= 1'b0;
    end else if (diff_start) begin
      diff_armed_ff <= 1'b1;
    end else if (diff_stop) begin
      diff_armed_ff <= 1'b0;
    end
  end

  // counter next value; core byte writes take effect when no tick or difference start lands
  always_comb begin
    nxt_count = count_ff;
    if (hit(acc, COUNTER_LOW_BYTE_ADDR)) begin
      nxt_count = {count_ff[15:8], acc.wdata}; // [RULE1]
    end else if (hit(acc, COUNTER_HIGH_BYTE_ADDR)) begin
      nxt_count = {acc.wdata, count_ff[7:0]}; // [RULE1]
    end
    if (mode == MODE_DIFF) begin
      if (diff_start) begin
        nxt_count = 16'h0000; // elapsed count starts at zero
      end else if (tick) begin
        nxt_count = count_ff + 16'h0001; // counts up [RULE22]
      end
    end else if (underflow) begin
      // capture mode has no reload, it wraps to all ones [RULE4]
      nxt_count = (mode == MODE_CAPTURE) ? COUNTER_RESET : reload_ff;
    end else if (tick) begin
      nxt_count = count_ff - 16'h0001; // [RULE3]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      count_ff <= COUNTER_RESET; // [RULE2]
    end else begin
      count_ff <= nxt_count;
    end
  end

  // reload/capture register; capture overrides a core write [RULE20]
  always_comb begin
    nxt_reload = reload_ff;
    if (hit(acc, RELOAD_LOW_BYTE_ADDR)) begin
      nxt_reload = {reload_ff[15:8], acc.wdata}; // [RULE1] [RULE10]
    end else if (hit(acc, RELOAD_HIGH_BYTE_ADDR)) begin
      nxt_reload = {acc.wdata, reload_ff[7:0]}; // [RULE1] [RULE10]
    end
    if (mode == MODE_DIFF && diff_stop) begin
      nxt_reload = count_ff + 16'h0001; // elapsed including this cycle
    end else if (mode == MODE_CAPTURE && capture) begin
      nxt_reload = count_ff; // [RULE20]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      reload_ff <= RELOAD_RESET; // [RULE2]
    end else begin
      reload_ff <= nxt_reload;
    end
  end

  // control register; hardware sets win over a same-cycle write
  always_comb begin
    nxt_ctl = ctl_ff;
    if (hit(acc, TIMER_CONTROL_ADDR)) begin
      nxt_ctl = acc.wdata & CONTROL_RESERVED_MASK; // bit 0 reads zero
    end
    // pending: underflow in counting modes, capture in capture modes
    if (((mode == MODE_PWM || mode == MODE_EVENT) && underflow) ||
        capture) begin
      nxt_ctl[CTL_PENDING] = 1'b1; // [RULE8] [RULE13] [RULE24]
    end
    // in capture modes bit 4 is the underflow flag [RULE21]
    if ((mode == MODE_CAPTURE || mode == MODE_DIFF) &&
        ((underflow) || (mode == MODE_DIFF && tick &&
         count_ff == 16'hffff))) begin
      nxt_ctl[CTL_RUN_UFL] = 1'b1; // [RULE21] [RULE24]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctl_ff <= CONTROL_RESET; // [RULE2]
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // pwm toggle: invert pin level at each underflow [RULE9]
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pin_level_ff <= 1'b0;
    end else if (!PIN_DIR_OUT) begin
      pin_level_ff <= PIN_PORT_DATA; // preset from port data
    end else if (mode == MODE_PWM && edge_sel && underflow) begin
      pin_level_ff <= ~pin_level_ff; // [RULE9]
    end
  end

  // pin drive follows port direction; low enable means driving [RULE19]
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pin_out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      pin_out_ff <= (mode == MODE_PWM && edge_sel) ? pin_level_ff
                                                   : PIN_PORT_DATA;
      oe_n_ff <= ~PIN_DIR_OUT; // [RULE19]
    end
  end

  // interrupt: level, dropped once the flag or either enable is cleared [RULE11]
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else begin
      // request holds while a flag is set and both enables are on
      irq_ff <= nxt_ctl[CTL_IRQ_ENABLE] && GLOBAL_IRQ_ENABLE &&
                (nxt_ctl[CTL_PENDING] ||
                 ((mode == MODE_CAPTURE || mode == MODE_DIFF) &&
                  nxt_ctl[CTL_RUN_UFL])); // [RULE5] [RULE11] [RULE21]
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_ff <= 8'h00;
    end else if (acc.rd) begin
      case (acc.addr)
        RELOAD_LOW_BYTE_ADDR: rdata_ff <= reload_ff[7:0]; // [RULE1]
        RELOAD_HIGH_BYTE_ADDR: rdata_ff <= reload_ff[15:8];
        COUNTER_LOW_BYTE_ADDR: rdata_ff <= count_ff[7:0];
        COUNTER_HIGH_BYTE_ADDR: rdata_ff <= count_ff[15:8];
        TIMER_CONTROL_ADDR: rdata_ff <= ctl_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign BUS_RDATA = rdata_ff;
  assign TIMER_PIN_OUT = pin_out_ff;
  assign TIMER_PIN_OE_N = oe_n_ff;
  assign TIMER_IRQ = irq_ff;
endmodule

/* bench/multimode_timer16_props.sv */
// port checker for the multimode timer, bound to its top module
module timer16_props
  import timer16_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic PIN_DIR_OUT,
  input wire logic PIN_PORT_DATA,
  input wire logic TIMER_PIN_IN,
  input wire logic TIMER_PIN_OUT,
  input wire logic TIMER_PIN_OE_N,
  input wire logic TIMER_IRQ
);
  logic [7:0] ctl_sh_ff;
  // software view of control; hardware flags are masked where used
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctl_sh_ff <= CONTROL_RESET;
    end else if (BUS_WR && BUS_ADDR == TIMER_CONTROL_ADDR) begin
      ctl_sh_ff <= BUS_WDATA;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_irq_global_gate: assert property (
    !GLOBAL_IRQ_ENABLE |=> !TIMER_IRQ)
    else $error("irq without global enable");
  chk_irq_local_gate: assert property (
    $rose(TIMER_IRQ)
    |-> ctl_sh_ff[CTL_IRQ_ENABLE] && $past(GLOBAL_IRQ_ENABLE))
    else $error("irq rose while disabled");
  chk_rsvd_bit_zero: assert property (
    BUS_RD && BUS_ADDR == TIMER_CONTROL_ADDR |=> !BUS_RDATA[0])
    else $error("reserved bit read as one");
  chk_unmapped_zero: assert property (
    BUS_RD && (BUS_ADDR < RELOAD_LOW_BYTE_ADDR ||
    BUS_ADDR > TIMER_CONTROL_ADDR) |=> BUS_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    !BUS_RD |=> $stable(BUS_RDATA))
    else $error("read data moved without a read");
  chk_ctl_readback: assert property (
    BUS_RD && !BUS_WR && BUS_ADDR == TIMER_CONTROL_ADDR
    |=> (BUS_RDATA & 8'he6) == ($past(ctl_sh_ff) & 8'he6))
    else $error("software control bits lost");
  // capture modes may overwrite reload, so only modes with bit 6 clear
  chk_reload_readback: assert property (
    BUS_WR && BUS_ADDR == RELOAD_LOW_BYTE_ADDR && !ctl_sh_ff[CTL_MODE_MID]
    ##1 !BUS_WR ##1 BUS_RD && !BUS_WR && BUS_ADDR == RELOAD_LOW_BYTE_ADDR
    |=> BUS_RDATA == $past(BUS_WDATA, 3))
    else $error("reload byte lost");
  chk_oe_follows_dir: assert property (
    PIN_DIR_OUT ##1 PIN_DIR_OUT |-> !TIMER_PIN_OE_N)
    else $error("pin not driven as output");
  cover property ($rose(TIMER_IRQ));
  cover property ($changed(TIMER_PIN_OUT));
  cover property (BUS_RD && BUS_ADDR == TIMER_CONTROL_ADDR);
endmodule
bind multimode_timer16 timer16_props u_props (.CLOCK, .RST, .BUS_WR,
  .BUS_RD, .BUS_ADDR, .BUS_WDATA, .BUS_RDATA, .GLOBAL_IRQ_ENABLE,
  .PIN_DIR_OUT, .PIN_PORT_DATA, .TIMER_PIN_IN, .TIMER_PIN_OUT,
  .TIMER_PIN_OE_N, .TIMER_IRQ);

/* bench/timer_pin_model.sv */
// far side of the timer pin: pulse source with pull-up, or a load
module timer_pin_model (
  input wire logic clk,
  input wire logic drive_val,
  input wire logic oe_n,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic src = 1'b1;
  // released line floats to the pull-up level
  assign pin = oe_n ? src : drive_val;
  // whole-cycle levels; callers keep n at 2 or more
  task automatic hold(input logic v, input int n);
    src = v;
    repeat (n) @(negedge clk);
  endtask
endmodule

/* bench/test_multimode_timer16.sv */
// self-checking bench for the multimode 16-bit timer
module test_multimode_timer16 import timer16_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic gie = 1'b0;
  logic dir_out = 1'b0;
  logic port_data = 1'b1;
  logic [7:0] bus_rdata;
  logic pin_in, pin_out, pin_oe_n, irq;
  int mismatches = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  multimode_timer16 dut (.CLOCK(clock), .RST(rst), .BUS_WR(bus_wr),
    .BUS_RD(bus_rd), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_RDATA(bus_rdata), .GLOBAL_IRQ_ENABLE(gie),
    .PIN_DIR_OUT(dir_out), .PIN_PORT_DATA(port_data), .TIMER_PIN_IN(pin_in),
    .TIMER_PIN_OUT(pin_out), .TIMER_PIN_OE_N(pin_oe_n), .TIMER_IRQ(irq));
  timer_pin_model src (.clk(clock), .drive_val(pin_out),
    .oe_n(pin_oe_n), .pin(pin_in));
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // strobes rise and fall on separate falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clock);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_rd = 1'b1;
    bus_addr = a;
    @(negedge clock);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask
  // 16-bit values travel as two independent bytes, low first
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
  task automatic wait_toggle(output int n);
    logic last;
    last = pin_out;
    for (n = 1; n <= 50; n++) begin
      @(negedge clock);
      if (pin_out !== last) break;
    end
    if (n > 50) begin
      check(1'b0, "pin never toggled");
      end_of_test();
    end
  endtask
  task automatic t_reset();
    logic [15:0] v;
    logic [7:0] b;
    rd16(COUNTER_LOW_BYTE_ADDR, v);
    check(v === COUNTER_RESET, "counter reset");
    rd16(RELOAD_LOW_BYTE_ADDR, v);
    check(v === RELOAD_RESET, "reload reset");
    rd(TIMER_CONTROL_ADDR, b);
    check(b === CONTROL_RESET, "control reset");
    rd(8'hb0, b);
    check(b === 8'h00, "unmapped read");
    wr(TIMER_CONTROL_ADDR, 8'h03);
    rd(TIMER_CONTROL_ADDR, b);
    check(b === 8'h02, "reserved bit");
    wr(RELOAD_LOW_BYTE_ADDR, 8'h5a);
    rd(RELOAD_LOW_BYTE_ADDR, b);
    check(b === 8'h5a, "reload byte");
  endtask
  // preload 2 counts three rising edges; zero alone must not flag
  task automatic t_event();
    logic [15:0] v;
    logic [7:0] b;
    gie = 1'b1;
    wr16(COUNTER_LOW_BYTE_ADDR, 16'h0002);
    wr16(RELOAD_LOW_BYTE_ADDR, 16'h0002);
    wr(TIMER_CONTROL_ADDR, 8'h14);
    repeat (2) begin
      src.hold(1'b0, 2);
      src.hold(1'b1, 6);
    end
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b0 && irq === 1'b0, "flag at zero");
    src.hold(1'b0, 2);
    src.hold(1'b1, 6);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1 && irq === 1'b1, "no underflow");
    rd16(COUNTER_LOW_BYTE_ADDR, v);
    check(v === 16'h0002, "event reload");
    wr(TIMER_CONTROL_ADDR, 8'h14);
    repeat (2) @(negedge clock);
    check(irq === 1'b0, "irq stuck after clear");
    // falling edges only: two full pulses plus one lone fall
    wr(TIMER_CONTROL_ADDR, 8'h34);
    repeat (2) begin
      src.hold(1'b0, 2);
      src.hold(1'b1, 2);
    end
    src.hold(1'b0, 4);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1, "falling events");
    src.hold(1'b1, 4);
  endtask
  task automatic t_pwm();
    int n;
    logic [7:0] b;
    dir_out = 1'b1;
    wr16(COUNTER_LOW_BYTE_ADDR, 16'h0003);
    wr16(RELOAD_LOW_BYTE_ADDR, 16'h0003);
    wr(TIMER_CONTROL_ADDR, 8'hb0);
    wait_toggle(n);
    check(n == 5, "start level");
    wait_toggle(n);
    check(n == 4, "pwm period");
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1 && irq === 1'b0, "pwm flag");
    wr16(RELOAD_LOW_BYTE_ADDR, 16'h0005);
    repeat (3) wait_toggle(n);
    check(n == 6, "new reload");
    wr(TIMER_CONTROL_ADDR, 8'ha0);
    b[0] = pin_out;
    repeat (12) @(negedge clock);
    check(pin_out === b[0], "stopped timer toggled");
    // no-toggle pwm: pin follows port data, flag still sets
    port_data = 1'b0;
    wr(TIMER_CONTROL_ADDR, 8'h90);
    repeat (12) @(negedge clock);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1 && pin_out === 1'b0, "no toggle");
    dir_out = 1'b0;
  endtask
  task automatic t_capture();
    logic [15:0] v;
    logic [7:0] b;
    wr(TIMER_CONTROL_ADDR, 8'h00);
    wr16(COUNTER_LOW_BYTE_ADDR, 16'h0004);
    wr(TIMER_CONTROL_ADDR, 8'h40);
    repeat (10) @(negedge clock);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[4:3] === 2'b10, "capture underflow");
    src.hold(1'b0, 2);
    src.hold(1'b1, 6);
    rd16(RELOAD_LOW_BYTE_ADDR, v);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1 && v[15:8] === 8'hff, "rise");
    wr(TIMER_CONTROL_ADDR, 8'h60);
    src.hold(1'b0, 6);
    rd(TIMER_CONTROL_ADDR, b);
    check(b[3] === 1'b1, "falling capture");
  endtask
  // every edge pair; second edge 5 cycles after an opposite first, else 6
  task automatic t_diff();
    logic [15:0] v;
    logic [7:0] b;
    logic p;
    for (int i = 0; i < 4; i++) begin
      p = i[1];
      wr(TIMER_CONTROL_ADDR, 8'h00);
      src.hold(p, 6);
      wr(TIMER_CONTROL_ADDR, {2'b11, p, 3'b000, i[0], 1'b0});
      src.hold(!p, i[0] ? 3 : 5);
      if (i[0]) src.hold(p, 3);
      src.hold(i[0] ? !p : p, 8);
      rd16(RELOAD_LOW_BYTE_ADDR, v);
      rd(TIMER_CONTROL_ADDR, b);
      check(v === 16'h0005 + i[0], "diff count");
      check(b[3] === 1'b1, "diff flag");
    end
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_event();
    t_pwm();
    t_capture();
    t_diff();
    end_of_test();
  end
  initial begin
    #200000;
    check(1'b0, "run timeout");
    end_of_test();
  end
endmodule
